// File: shared/gmbc_pkg.sv
package gmbc_pkg;

  // register byte addresses on the 2-wire register space
  localparam logic [15:0] ADDR_MODE_7_6 = 16'h1001;
  localparam logic [15:0] ADDR_MODE_5_4 = 16'h1002;
  localparam logic [15:0] ADDR_MODE_3_2 = 16'h1003;
  localparam logic [15:0] ADDR_MODE_1_0 = 16'h1004;
  localparam int          NUM_MODE_REGS = 4;

  // field layout inside one mode register
  localparam int          ODD_FIELD_LSB  = 4;
  localparam int          EVEN_FIELD_LSB = 0;
  localparam int          FIELD_W        = 4;
  localparam logic [7:0]  MODE_REG_RESET = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ  = 8'h00;

  // synchroniser depth for pin inputs
  localparam int          SYNC_STAGES = 2;

  // default 7-bit device addresses of both 2-wire ports (arbitrary)
  localparam logic [6:0]  PRI_DEV_ADDR = 7'h2A;
  localparam logic [6:0]  SEC_DEV_ADDR = 7'h2B;

  typedef enum logic [3:0] {
    MODE_DISABLED   = 4'h0,
    MODE_DRIVE_LOW  = 4'h1,
    MODE_DRIVE_HIGH = 4'h2,
    MODE_BRIDGE_IN  = 4'h3,
    MODE_BRIDGE_OUT = 4'h4,
    MODE_SEC_CLOCK  = 4'h5,
    MODE_SEC_DATA   = 4'h6
  } gmbc_mode_t;

  typedef enum logic [2:0] {
    TWI_IDLE    = 3'b000,
    TWI_ADDR    = 3'b001,
    TWI_ACK     = 3'b010,
    TWI_RX      = 3'b011,
    TWI_TX      = 3'b100,
    TWI_HOSTACK = 3'b101
  } gmbc_twi_state_t;

endpackage : gmbc_pkg

// File: hdl/gmbc_twi_slave.sv
module gmbc_twi_slave #(
  parameter logic [6:0] DEV_ADDR = gmbc_pkg::PRI_DEV_ADDR
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        sclLevel,
  input  wire logic        sdaLevel,
  output logic             sdaOe,
  output logic [15:0]      regAddr,
  output logic [7:0]       wrData,
  output logic             wrStrobe,
  input  wire logic [7:0]  rdData
);

  gmbc_pkg::gmbc_twi_state_t state_q;
  logic        sclPrev_q;
  logic        sdaPrev_q;
  logic [3:0]  bitCnt_q;
  logic [7:0]  shift_q;
  logic [1:0]  byteIdx_q;
  logic        isRead_q;
  logic        afterAddr_q;

  logic sclRise, sclFall, startSeen, stopSeen;

  // levels arrive already synchronised, so edges may be taken here
  assign sclRise   = sclLevel & ~sclPrev_q;
  assign sclFall   = ~sclLevel & sclPrev_q;
  assign startSeen = sclLevel & sclPrev_q & sdaPrev_q & ~sdaLevel;
  assign stopSeen  = sclLevel & sclPrev_q & ~sdaPrev_q & sdaLevel;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclPrev_q <= sclLevel;
      sdaPrev_q <= sdaLevel;
    end
  end

  // byte engine; no clock stretching, the bus master sets the pace
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q     <= gmbc_pkg::TWI_IDLE;
      bitCnt_q    <= 4'h0;
      shift_q     <= 8'h00;
      byteIdx_q   <= 2'h0;
      isRead_q    <= 1'b0;
      afterAddr_q <= 1'b0;
      sdaOe       <= 1'b0;
      regAddr     <= 16'h0000;
      wrData      <= 8'h00;
      wrStrobe    <= 1'b0;
    end else begin
      wrStrobe <= 1'b0;
      // step only after a data byte, so the write itself still sees the old address
      if (wrStrobe) begin
        regAddr <= regAddr + 16'h0001;
      end
      if (startSeen) begin
        state_q  <= gmbc_pkg::TWI_ADDR;
        bitCnt_q <= 4'h0;
        sdaOe    <= 1'b0;
      end else if (stopSeen) begin
        state_q <= gmbc_pkg::TWI_IDLE;
        sdaOe   <= 1'b0;
      end else begin
        case (state_q)
          gmbc_pkg::TWI_ADDR, gmbc_pkg::TWI_RX: begin
            if (sclRise && bitCnt_q < 4'h8) begin
              shift_q  <= {shift_q[6:0], sdaLevel};
              bitCnt_q <= bitCnt_q + 4'h1;
            end else if (sclFall && bitCnt_q == 4'h8) begin
              bitCnt_q <= 4'h0;
              if (state_q == gmbc_pkg::TWI_ADDR) begin
                // another device's address: stay off the bus
                if (shift_q[7:1] == DEV_ADDR) begin
                  isRead_q    <= shift_q[0];
                  afterAddr_q <= 1'b1;
                  byteIdx_q   <= 2'h0;
                  sdaOe       <= 1'b1;
                  state_q     <= gmbc_pkg::TWI_ACK;
                end else begin
                  state_q <= gmbc_pkg::TWI_IDLE;
                end
              end else begin
                afterAddr_q <= 1'b0;
                sdaOe       <= 1'b1;
                state_q     <= gmbc_pkg::TWI_ACK;
                case (byteIdx_q)
                  2'h0: regAddr[15:8] <= shift_q;
                  2'h1: regAddr[7:0]  <= shift_q;
                  default: begin
                    wrData   <= shift_q;
                    wrStrobe <= 1'b1;
                  end
                endcase
                if (byteIdx_q != 2'h2) begin
                  byteIdx_q <= byteIdx_q + 2'h1;
                end
              end
            end
          end
          gmbc_pkg::TWI_ACK: begin
            if (sclFall) begin
              if (afterAddr_q && isRead_q) begin
                shift_q  <= {rdData[6:0], 1'b0};
                sdaOe    <= ~rdData[7];
                bitCnt_q <= 4'h1;
                state_q  <= gmbc_pkg::TWI_TX;
              end else begin
                sdaOe   <= 1'b0;
                state_q <= gmbc_pkg::TWI_RX;
              end
            end
          end
          gmbc_pkg::TWI_TX: begin
            if (sclFall) begin
              if (bitCnt_q == 4'h8) begin
                sdaOe   <= 1'b0;
                state_q <= gmbc_pkg::TWI_HOSTACK;
              end else begin
                sdaOe    <= ~shift_q[7];
                shift_q  <= {shift_q[6:0], 1'b0};
                bitCnt_q <= bitCnt_q + 4'h1;
              end
            end
          end
          gmbc_pkg::TWI_HOSTACK: begin
            if (sclRise) begin
              regAddr <= regAddr + 16'h0001;
              // a not-acknowledge ends the read burst
              if (sdaLevel) begin
                state_q <= gmbc_pkg::TWI_IDLE;
              end else begin
                afterAddr_q <= 1'b1;
                isRead_q    <= 1'b1;
                state_q     <= gmbc_pkg::TWI_ACK;
              end
            end
          end
          default: begin
            sdaOe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule : gmbc_twi_slave

// File: hdl/gmbc_top.sv
// Behaviour
// [R1] each pin has a 4-bit mode: 0 off, 1 drive low, 2 drive high
// [R2] mode 3 sends pin level to remote; mode 4 drives pin from remote level
// [R3] mode 5 is secondary 2-wire clock line, mode 6 its data line
// [R4] software never writes mode values 7 to 15; they act as disabled here
// [R5] all mode fields reset to zero, every pin disabled
// [R6] two fields per byte, odd pin high nibble, registers 7/6 to 1/0 ascending
// [R7] bridged input level is sampled once per side-link poll
// [R8] sample spacing follows the poll strobe, however long each poll takes
// [R9] first companion type: pin 1 goes to remote slot 4, pin 0 to slot 3
// [R10] second companion: pins 0/1 on lane 0, pins 2/3 from selected lane; here all pins latch from the selected lane only
// [R11] bridged UART baud rate is chosen against the poll interval
// [R12] secondary 2-wire port reaches the registers independently of primary
// [R13] disabled pin is not driven and its input is ignored
module gmbc_top #(
  parameter int         PINS         = 8,
  parameter logic [6:0] PRI_ADDR     = gmbc_pkg::PRI_DEV_ADDR,
  parameter logic [6:0] SEC_ADDR     = gmbc_pkg::SEC_DEV_ADDR
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             sclIn,
  input  wire logic             sdaIn,
  output logic                  sdaOut,
  output logic                  sdaOe,
  input  wire logic [PINS-1:0]  gpioIn,
  output logic      [PINS-1:0]  gpioOut,
  output logic      [PINS-1:0]  gpioOe,
  input  wire logic             companionType,
  input  wire logic             pollStrobe,
  input  wire logic             pollLane,
  input  wire logic             rxLaneSel,
  input  wire logic [PINS-1:0]  rxLevels,
  output logic      [PINS-1:0]  remoteTx
);

  logic [7:0]      modeReg_q [gmbc_pkg::NUM_MODE_REGS];
  logic [PINS-1:0] pinSync1_q, pinSync2_q;
  logic [1:0]      twiSync1_q, twiSync2_q;
  logic [PINS-1:0] rxLatched_q;
  logic [PINS-1:0] sampled;
  logic            secScl, secSda;
  logic            priSdaOe, secSdaOe;
  logic [15:0]     priAddr, secAddr;
  logic [7:0]      priWrData, secWrData, priRdData, secRdData;
  logic            priWr, secWr;

  // register index from byte address; -1 marks an unmapped address
  function automatic int regIndex(input logic [15:0] addr);
    case (addr)
      gmbc_pkg::ADDR_MODE_7_6: regIndex = 0;
      gmbc_pkg::ADDR_MODE_5_4: regIndex = 1;
      gmbc_pkg::ADDR_MODE_3_2: regIndex = 2;
      gmbc_pkg::ADDR_MODE_1_0: regIndex = 3;
      default:                 regIndex = -1;
    endcase
  endfunction : regIndex

  // mode field of pin p: pin 7/6 in register 0, odd pin in high nibble
  function automatic logic [3:0] pinMode(input int p, input logic [7:0] r);
    pinMode = p[0] ? r[gmbc_pkg::ODD_FIELD_LSB +: gmbc_pkg::FIELD_W]
                   : r[gmbc_pkg::EVEN_FIELD_LSB +: gmbc_pkg::FIELD_W]; // R6
  endfunction : pinMode

  function automatic logic [7:0] readReg(input logic [15:0] addr,
                                         input logic [7:0] r0, input logic [7:0] r1,
                                         input logic [7:0] r2, input logic [7:0] r3);
    case (regIndex(addr))
      0:       readReg = r0;
      1:       readReg = r1;
      2:       readReg = r2;
      3:       readReg = r3;
      default: readReg = gmbc_pkg::UNMAPPED_READ;
    endcase
  endfunction : readReg

  // two-stage synchronisers for every pin that reaches logic
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pinSync1_q <= '0;
      pinSync2_q <= '0;
      twiSync1_q <= 2'b11;
      twiSync2_q <= 2'b11;
    end else begin
      pinSync1_q <= gpioIn;
      pinSync2_q <= pinSync1_q;
      twiSync1_q <= {sclIn, sdaIn};
      twiSync2_q <= twiSync1_q;
    end
  end

  // secondary port lines: lowest pin in each mode wins, idle high otherwise
  always_comb begin
    secScl = 1'b1;
    secSda = 1'b1;
    for (int p = PINS - 1; p >= 0; p--) begin
      if (pinMode(p, modeReg_q[3 - p / 2]) == gmbc_pkg::MODE_SEC_CLOCK) begin
        secScl = pinSync2_q[p]; // R3
      end
      if (pinMode(p, modeReg_q[3 - p / 2]) == gmbc_pkg::MODE_SEC_DATA) begin
        secSda = pinSync2_q[p]; // R3
      end
    end
  end

  gmbc_twi_slave #(
    .DEV_ADDR (PRI_ADDR)
  ) u_primary (
    .clk      (clk),
    .rstn     (rstn),
    .sclLevel (twiSync2_q[1]),
    .sdaLevel (twiSync2_q[0]),
    .sdaOe    (priSdaOe),
    .regAddr  (priAddr),
    .wrData   (priWrData),
    .wrStrobe (priWr),
    .rdData   (priRdData)
  );

  // an independent engine, so two processors never share state
  gmbc_twi_slave #(
    .DEV_ADDR (SEC_ADDR)
  ) u_secondary (
    .clk      (clk),
    .rstn     (rstn),
    .sclLevel (secScl),
    .sdaLevel (secSda),
    .sdaOe    (secSdaOe),
    .regAddr  (secAddr),
    .wrData   (secWrData),
    .wrStrobe (secWr),
    .rdData   (secRdData)
  ); // R12

  assign priRdData = readReg(priAddr, modeReg_q[0], modeReg_q[1], modeReg_q[2], modeReg_q[3]);
  assign secRdData = readReg(secAddr, modeReg_q[0], modeReg_q[1], modeReg_q[2], modeReg_q[3]);
  assign sdaOut    = 1'b0;
  assign sdaOe     = priSdaOe;

  // mode registers; same-cycle writes to one register: primary wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < gmbc_pkg::NUM_MODE_REGS; i++) begin
        modeReg_q[i] <= gmbc_pkg::MODE_REG_RESET; // R5
      end
    end else begin
      for (int i = 0; i < gmbc_pkg::NUM_MODE_REGS; i++) begin
        if (priWr && regIndex(priAddr) == i) begin
          modeReg_q[i] <= priWrData; // R6
        end else if (secWr && regIndex(secAddr) == i) begin
          modeReg_q[i] <= secWrData; // R12
        end
      end
    end
  end

  // pin drivers; reserved codes fall into the default and float the pin
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gpioOut <= '0;
      gpioOe  <= '0;
    end else begin
      for (int p = 0; p < PINS; p++) begin
        case (pinMode(p, modeReg_q[3 - p / 2]))
          gmbc_pkg::MODE_DRIVE_LOW: begin
            gpioOut[p] <= 1'b0; // R1
            gpioOe[p]  <= 1'b1;
          end
          gmbc_pkg::MODE_DRIVE_HIGH: begin
            gpioOut[p] <= 1'b1; // R1
            gpioOe[p]  <= 1'b1;
          end
          gmbc_pkg::MODE_BRIDGE_OUT: begin
            gpioOut[p] <= rxLatched_q[p]; // R2
            gpioOe[p]  <= 1'b1;
          end
          gmbc_pkg::MODE_SEC_DATA: begin
            gpioOut[p] <= 1'b0; // R3
            gpioOe[p]  <= secSdaOe;
          end
          default: begin
            gpioOut[p] <= 1'b0; // R13 R4
            gpioOe[p]  <= 1'b0;
          end
        endcase
      end
    end
  end

  // only bridged-input pins contribute; disabled pins read as zero
  always_comb begin
    for (int p = 0; p < PINS; p++) begin
      sampled[p] = (pinMode(p, modeReg_q[3 - p / 2]) == gmbc_pkg::MODE_BRIDGE_IN)
                   & pinSync2_q[p]; // R2 R13
    end
  end

  // one sample per poll; a slow remote transaction only delays the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      remoteTx <= '0;
    end else if (pollStrobe) begin // R7 R8
      if (!companionType) begin
        remoteTx <= {sampled[7:5], sampled[1], sampled[0], sampled[2], 2'b00}; // R9
      end else begin
        remoteTx <= sampled; // R10
      end
    end
  end

  // remote levels; the second companion only updates from the chosen lane
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxLatched_q <= '0;
    end else if (pollStrobe && (!companionType || pollLane == rxLaneSel)) begin
      rxLatched_q <= rxLevels; // R10
    end
  end

  a_reset_disabled: assert property (@(posedge clk) // R5
    $rose(rstn) |-> gpioOe == '0 && remoteTx == '0)
    else $error("pins not disabled after reset");

  a_drive_low: assert property (@(posedge clk) disable iff (!rstn) // R1
    pinMode(0, modeReg_q[3]) == gmbc_pkg::MODE_DRIVE_LOW |=> gpioOe[0] && !gpioOut[0])
    else $error("pin 0 not driven low");

  a_drive_high: assert property (@(posedge clk) disable iff (!rstn) // R1
    pinMode(7, modeReg_q[0]) == gmbc_pkg::MODE_DRIVE_HIGH |=> gpioOe[7] && gpioOut[7])
    else $error("pin 7 not driven high");

  a_disabled_float: assert property (@(posedge clk) disable iff (!rstn) // R13
    pinMode(2, modeReg_q[2]) == gmbc_pkg::MODE_DISABLED ##1 pollStrobe
    && pinMode(2, modeReg_q[2]) == gmbc_pkg::MODE_DISABLED |=> !gpioOe[2])
    else $error("disabled pin driven");

  a_bridge_out: assert property (@(posedge clk) disable iff (!rstn) // R2
    (pinMode(4, modeReg_q[1]) == gmbc_pkg::MODE_BRIDGE_OUT) [*2]
    |-> gpioOut[4] == $past(rxLatched_q[4]))
    else $error("bridged output not following remote");

  a_poll_hold: assert property (@(posedge clk) disable iff (!rstn) // R7
    !pollStrobe |=> $stable(remoteTx))
    else $error("remote level changed without a poll");

  a_map_first: assert property (@(posedge clk) disable iff (!rstn) // R9
    pollStrobe && !companionType |=> remoteTx[4] == $past(sampled[1])
    && remoteTx[3] == $past(sampled[0]))
    else $error("first companion mapping wrong");

  a_lane_select: assert property (@(posedge clk) disable iff (!rstn) // R10
    pollStrobe && companionType && pollLane != rxLaneSel |=> $stable(rxLatched_q))
    else $error("unselected lane updated bridged outputs");

  a_sec_write: assert property (@(posedge clk) disable iff (!rstn) // R12
    secWr && !priWr && regIndex(secAddr) == 3 |=> modeReg_q[3] == $past(secWrData))
    else $error("secondary port write lost");

endmodule : gmbc_top

// File: verification/gmbc_remote_model.sv
module gmbc_remote_model (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [7:0] interval,
  input  wire logic [7:0] txVal,
  output logic            pollStrobe,
  output logic            pollLane,
  output logic [7:0]      rxLevels
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] cnt_q;

  // poll timer; levels are only meaningful with the strobe, so they churn between polls
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q      <= 8'h00;
      pollStrobe <= 1'b0;
      pollLane   <= 1'b0;
      rxLevels   <= 8'h00;
    end else if (cnt_q >= interval) begin
      cnt_q      <= 8'h00;
      pollStrobe <= 1'b1;
      pollLane   <= ~pollLane;
      rxLevels   <= txVal;
    end else begin
      cnt_q      <= cnt_q + 8'h01;
      pollStrobe <= 1'b0;
      rxLevels   <= ~rxLevels;
    end
  end
endmodule : gmbc_remote_model

// File: verification/gpio_mode_and_bridge_control_tb.sv
module gpio_mode_and_bridge_control_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk, rstn, sclM, sdaM, useSec, companionType, rxLaneSel, l;
  logic        sdaOut, sdaOe, pollStrobe, pollLane;
  logic [7:0]  gpioDrv, gpioOut, gpioOe, remoteTx, rxLevels, txVal, interval;
  logic [7:0]  d, g, v, mask, old, eo, eu;
  logic [3:0]  m [8];
  logic [31:0] seed = 32'h00018664;
  int          nChecks, failCount;

  // open-drain buses: a released line is pulled high
  wire logic       sclIn  = useSec ? 1'b1 : sclM;
  wire logic       sdaIn  = useSec ? 1'b1 : (sdaM & ~sdaOe);
  wire logic [7:0] gpioIn = useSec ? {gpioDrv[7], sdaM & ~gpioOe[6], sclM, gpioDrv[4:0]} : gpioDrv;
  wire logic       busSda = useSec ? gpioIn[6] : sdaIn;

  gmbc_top dut_u (
    .clk(clk), .rstn(rstn), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe), .companionType(companionType),
    .pollStrobe(pollStrobe), .pollLane(pollLane), .rxLaneSel(rxLaneSel),
    .rxLevels(rxLevels), .remoteTx(remoteTx)
  );

  gmbc_remote_model remote_u (
    .clk(clk), .rstn(rstn), .interval(interval), .txVal(txVal),
    .pollStrobe(pollStrobe), .pollLane(pollLane), .rxLevels(rxLevels)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [7:0] rnd8();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd8

  function automatic logic [7:0] expTx(input logic c, input logic [7:0] s);
    return c ? s : {s[7], s[6], s[5], s[1], s[0], s[2], 2'b00};
  endfunction : expTx

  // inputs always move a fixed 5 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : tick

  task automatic chk(input logic [7:0] e, input logic [7:0] q);
    nChecks++;
    if (q !== e) begin
      failCount++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, q);
    end
  endtask : chk

  task automatic stopTest();
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stopTest

  // one bit: data set in the low phase, sampled late in the high phase
  task automatic bitx(input logic b, output logic r);
    sdaM = b;
    tick(4);
    sclM = 1'b1;
    tick(5);
    r = busSda;
    sclM = 1'b0;
    tick(2);
  endtask : bitx

  task automatic xfer(input logic [7:0] x, input logic wantAck, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) bitx(x[i], r[i]);
    bitx(1'b1, a);
    if (wantAck) chk(8'h01, {7'h00, ~a});
  endtask : xfer

  task automatic startC();
    sdaM = 1'b1;
    tick(4);
    sclM = 1'b1;
    tick(5);
    sdaM = 1'b0;
    tick(5);
    sclM = 1'b0;
    tick(2);
  endtask : startC

  task automatic head(input logic [15:0] a);
    logic [7:0] r;
    startC();
    xfer({useSec ? gmbc_pkg::SEC_DEV_ADDR : gmbc_pkg::PRI_DEV_ADDR, 1'b0}, 1'b1, r);
    xfer(a[15:8], 1'b1, r);
    xfer(a[7:0], 1'b1, r);
  endtask : head

  task automatic stopC();
    sdaM = 1'b0;
    tick(4);
    sclM = 1'b1;
    tick(5);
    sdaM = 1'b1;
    tick(5);
  endtask : stopC

  task automatic wrReg(input logic [15:0] a, input logic [7:0] x);
    logic [7:0] r;
    head(a);
    xfer(x, 1'b1, r);
    stopC();
  endtask : wrReg

  task automatic rdReg(input logic [15:0] a, output logic [7:0] x);
    logic [7:0] r;
    head(a);
    startC();
    xfer({useSec ? gmbc_pkg::SEC_DEV_ADDR : gmbc_pkg::PRI_DEV_ADDR, 1'b1}, 1'b1, r);
    xfer(8'hFF, 1'b0, x);
    stopC();
  endtask : rdReg

  // program all four mode registers from m[] and read each one back
  task automatic setModes();
    logic [7:0] r;
    for (int k = 0; k < 4; k++) wrReg(gmbc_pkg::ADDR_MODE_7_6 + 16'(k), {m[7-2*k], m[6-2*k]});
    for (int k = 0; k < 4; k++) begin
      rdReg(gmbc_pkg::ADDR_MODE_7_6 + 16'(k), r);
      chk({m[7-2*k], m[6-2*k]}, r);
    end
  endtask : setModes

  // bounded wait for a poll, then let latch and pin registers settle
  task automatic waitPoll(output logic lane, output logic [7:0] lv);
    int n;
    n = 0;
    while (pollStrobe !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    if (n >= 200) begin
      failCount++;
      stopTest();
    end
    lane = pollLane;
    lv = rxLevels;
    tick(3);
  endtask : waitPoll

  initial begin
    rstn = 1'b0;
    sclM = 1'b1;
    sdaM = 1'b1;
    useSec = 1'b0;
    companionType = 1'b0;
    rxLaneSel = 1'b0;
    gpioDrv = 8'h00;
    interval = 8'h14;
    txVal = 8'h00;
    repeat (3) @(posedge clk);
    #5;
    rstn = 1'b1;
    tick(4);
    chk(8'h00, gpioOe);
    chk(8'h00, remoteTx);
    chk(8'h00, {6'h00, sdaOut, sdaOe});
    // 0x1000 is unmapped and reads as zero
    for (int a = 0; a < 5; a++) begin
      rdReg(16'h1000 + 16'(a), d);
      chk(8'h00, d);
    end
    // random fixed-level modes over all pins
    repeat (3) begin
      for (int p = 0; p < 8; p++) begin
        m[p] = 4'(rnd8() % 8'h03);
        eo[p] = (m[p] != 4'h0);
        eu[p] = (m[p] == 4'h2);
      end
      setModes();
      chk(eo, gpioOe);
      chk(eu, gpioOut & eo);
    end
    // bridged inputs, both companion mappings
    for (int c = 0; c < 2; c++) begin
      companionType = c[0];
      mask = rnd8();
      for (int p = 0; p < 8; p++) m[p] = mask[p] ? 4'h3 : 4'h0;
      setModes();
      gpioDrv = rnd8();
      waitPoll(l, v);
      waitPoll(l, v);
      old = expTx(c[0], gpioDrv & mask);
      chk(old, remoteTx);
      gpioDrv = ~gpioDrv;
      tick(8);
      chk(old, remoteTx);
      waitPoll(l, v);
      chk(expTx(c[0], gpioDrv & mask), remoteTx);
    end
    // bridged outputs, then lane selection
    companionType = 1'b0;
    for (int p = 0; p < 8; p++) m[p] = 4'h4;
    setModes();
    txVal = rnd8();
    waitPoll(l, v);
    waitPoll(l, v);
    chk(v, gpioOut);
    chk(8'hFF, gpioOe);
    companionType = 1'b1;
    rxLaneSel = 1'b1;
    repeat (4) begin
      old = gpioOut;
      txVal = rnd8();
      waitPoll(l, v);
      chk((l == rxLaneSel) ? v : old, gpioOut);
    end
    // secondary port on pins 5 and 6
    companionType = 1'b0;
    gpioDrv = 8'hFF;
    for (int p = 0; p < 8; p++) m[p] = 4'h0;
    m[5] = 4'h5;
    m[6] = 4'h6;
    setModes();
    chk(8'h00, gpioOe);
    useSec = 1'b1;
    tick(4);
    // pins 1/0 stay off the port modes, or the port would move mid-run
    d = {4'(rnd8() % 8'h05), 4'(rnd8() % 8'h05)};
    wrReg(gmbc_pkg::ADDR_MODE_1_0, d);
    rdReg(gmbc_pkg::ADDR_MODE_1_0, g);
    chk(d, g);
    useSec = 1'b0;
    tick(4);
    rdReg(gmbc_pkg::ADDR_MODE_1_0, g);
    chk(d, g);
    stopTest();
  end
endmodule : gpio_mode_and_bridge_control_tb
